// File: hdl/cal_and_gpio_register_bank.sv
/*
  Calibration word and general-purpose pin register bank behind a
  four-wire serial link in clock mode 1.
  Assumes sclk_i, cs_n_i, din_i and gpio_i are asynchronous to mclk_i,
  with the serial clock well below a quarter of mclk_i. Frame: one
  command byte (bit 7 read, bits 4:0 address) then one data byte,
  most significant bit first.
*/
`timescale 1ns/10ps
module cal_and_gpio_register_bank #(
  parameter bit SIX_INPUT = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic [cal_gpio_pkg::NPINS-1:0] gpio_i,
  output logic [cal_gpio_pkg::NPINS-1:0] gpio_o,
  output logic [cal_gpio_pkg::NPINS-1:0] gpio_oe_o,
  output logic [cal_gpio_pkg::NPINS-1:0] pin_analog_o,
  output logic [cal_gpio_pkg::NPINS-1:0] pin_enabled_o,
  output logic [15:0] offset_corr_value_o,
  output logic [15:0] gain_corr_value_o
);
  import cal_gpio_pkg::*;

  // two-stage synchronisers for every asynchronous input
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [NPINS-1:0] gpio_s1_r;
  logic [NPINS-1:0] gpio_s2_r;
  logic sclk_d_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync1_r <= 3'h2;
      sync2_r <= 3'h2;
      gpio_s1_r <= 4'h0;
      gpio_s2_r <= 4'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r <= {din_i, cs_n_i, sclk_i};
      sync2_r <= sync1_r;
      gpio_s1_r <= gpio_i;
      gpio_s2_r <= gpio_s1_r;
      sclk_d_r <= sync2_r[0];
    end
  end

  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_on;

  assign sclk_s = sync2_r[0];
  assign cs_n_s = sync2_r[1];
  assign din_s = sync2_r[2];
  assign frame_on = !cs_n_s;
  assign sclk_rise = frame_on && sclk_s && !sclk_d_r;
  assign sclk_fall = frame_on && !sclk_s && sclk_d_r;

  // link state
  link_state_t state_r;
  link_state_t state_nxt;
  logic [3:0] bitcnt_r;
  logic [3:0] bitcnt_nxt;
  logic [BYTE_W-1:0] shift_r;
  logic [BYTE_W-1:0] shift_nxt;
  logic [BYTE_W-1:0] cmd_r;
  logic [BYTE_W-1:0] cmd_nxt;
  logic [BYTE_W-1:0] tx_r;
  logic [BYTE_W-1:0] tx_nxt;
  logic dout_r;
  logic dout_nxt;
  logic dout_oe_r;
  logic dout_oe_nxt;

  // register state
  logic [BYTE_W-1:0] ofs_lo_r;
  logic [BYTE_W-1:0] ofs_lo_nxt;
  logic [BYTE_W-1:0] ofs_hi_r;
  logic [BYTE_W-1:0] ofs_hi_nxt;
  logic [BYTE_W-1:0] gain_lo_r;
  logic [BYTE_W-1:0] gain_lo_nxt;
  logic [BYTE_W-1:0] gain_hi_r;
  logic [BYTE_W-1:0] gain_hi_nxt;
  logic [NPINS-1:0] pin_dir_r;
  logic [NPINS-1:0] pin_dir_nxt;
  logic [NPINS-1:0] pin_level_r;
  logic [NPINS-1:0] pin_level_nxt;
  logic [NPINS-1:0] pin_digital_select_r;
  logic [NPINS-1:0] pin_digital_select_nxt;

  // pin drivers, registered so outputs come straight from flops
  logic [NPINS-1:0] gpio_r;
  logic [NPINS-1:0] gpio_nxt;
  logic [NPINS-1:0] gpio_oe_r;
  logic [NPINS-1:0] gpio_oe_nxt;
  logic [NPINS-1:0] pin_read;

  // per-pin output driver and read-back select
  generate
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
      always_comb begin
        gpio_oe_nxt[i] = pin_digital_select_r[i] && !pin_dir_r[i];
        gpio_nxt[i] = pin_level_r[i] && gpio_oe_nxt[i];
        if (pin_digital_select_r[i] && pin_dir_r[i]) begin
          pin_read[i] = gpio_s2_r[i];
        end else begin
          pin_read[i] = pin_level_r[i];
        end
      end
    end
  endgenerate

  function automatic logic [BYTE_W-1:0] read_byte(
    input logic [ADDR_W-1:0] a
  );
    logic [BYTE_W-1:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_OFS_LO: v = ofs_lo_r;
      ADDR_OFS_HI: v = ofs_hi_r;
      ADDR_RSVD: v = RSVD_VAL;
      ADDR_GAIN_LO: v = gain_lo_r;
      ADDR_GAIN_HI: v = gain_hi_r;
      ADDR_PIN_DAT: v = {pin_dir_r, pin_read};
      ADDR_PIN_FUN: v = {4'h0, pin_digital_select_r};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_byte

  logic [BYTE_W-1:0] rx_byte;
  logic [ADDR_W-1:0] cmd_addr;
  logic do_write;

  assign rx_byte = {shift_r[BYTE_W-2:0], din_s};
  assign cmd_addr = cmd_r[ADDR_W-1:0];

  always_comb begin
    state_nxt = state_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    cmd_nxt = cmd_r;
    tx_nxt = tx_r;
    dout_nxt = dout_r;
    dout_oe_nxt = frame_on;
    do_write = 1'b0;
    if (!frame_on) begin
      state_nxt = ST_CMD;
      bitcnt_nxt = 4'h0;
      dout_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_CMD: begin
          if (sclk_fall) begin
            shift_nxt = rx_byte;
            bitcnt_nxt = bitcnt_r + 4'h1;
            if (bitcnt_r == CMD_LAST_BIT) begin
              cmd_nxt = rx_byte;
              tx_nxt = read_byte(rx_byte[ADDR_W-1:0]);
              state_nxt = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise && cmd_r[CMD_RD_BIT]) begin
            dout_nxt = tx_r[BYTE_W-1];
            tx_nxt = {tx_r[BYTE_W-2:0], 1'b0};
          end
          if (sclk_fall) begin
            shift_nxt = rx_byte;
            bitcnt_nxt = bitcnt_r + 4'h1;
            if (bitcnt_r == FRAME_BITS) begin
              do_write = !cmd_r[CMD_RD_BIT];
              state_nxt = ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // extra clocks only clear dout on each rise until chip select rises
          if (sclk_rise) begin
            dout_nxt = 1'b0;
          end
        end
      endcase
    end
  end

  always_comb begin
    ofs_lo_nxt = ofs_lo_r;
    ofs_hi_nxt = ofs_hi_r;
    gain_lo_nxt = gain_lo_r;
    gain_hi_nxt = gain_hi_r;
    pin_dir_nxt = pin_dir_r;
    pin_level_nxt = pin_level_r;
    pin_digital_select_nxt = pin_digital_select_r;
    if (do_write) begin
      unique case (cmd_addr)
        ADDR_OFS_LO: ofs_lo_nxt = rx_byte;
        ADDR_OFS_HI: ofs_hi_nxt = rx_byte;
        ADDR_GAIN_LO: gain_lo_nxt = rx_byte;
        ADDR_GAIN_HI: gain_hi_nxt = rx_byte;
        ADDR_PIN_DAT: begin
          pin_dir_nxt = rx_byte[DIR_LSB +: NPINS];
          pin_level_nxt = rx_byte[LEVEL_LSB +: NPINS];
        end
        ADDR_PIN_FUN: begin
          // upper nibble is read-only and dropped
          pin_digital_select_nxt = rx_byte[SEL_LSB +: NPINS];
        end
        default: begin
          // reserved byte and unmapped addresses take no write
          ofs_lo_nxt = ofs_lo_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_r <= ST_CMD;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      tx_r <= 8'h00;
      dout_r <= 1'b0;
      dout_oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      cmd_r <= cmd_nxt;
      tx_r <= tx_nxt;
      dout_r <= dout_nxt;
      dout_oe_r <= dout_oe_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ofs_lo_r <= RST_OFS_LO;
      ofs_hi_r <= RST_OFS_HI;
      gain_lo_r <= RST_GAIN_LO;
      gain_hi_r <= RST_GAIN_HI;
      pin_dir_r <= RST_PIN_DIR;
      pin_level_r <= RST_PIN_LEVEL;
      pin_digital_select_r <= RST_PIN_SEL;
      gpio_r <= 4'h0;
      gpio_oe_r <= 4'h0;
    end else begin
      ofs_lo_r <= ofs_lo_nxt;
      ofs_hi_r <= ofs_hi_nxt;
      gain_lo_r <= gain_lo_nxt;
      gain_hi_r <= gain_hi_nxt;
      pin_dir_r <= pin_dir_nxt;
      pin_level_r <= pin_level_nxt;
      pin_digital_select_r <= pin_digital_select_nxt;
      gpio_r <= gpio_nxt;
      gpio_oe_r <= gpio_oe_nxt;
    end
  end

  // on the six-input variant a pin is only enabled once selected digital
  logic [NPINS-1:0] analog_r;
  logic [NPINS-1:0] enabled_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      analog_r <= 4'hF;
      enabled_r <= 4'h0;
    end else begin
      analog_r <= ~pin_digital_select_r;
      enabled_r <= SIX_INPUT ? pin_digital_select_r : 4'hF;
    end
  end

  assign dout_o = dout_r;
  assign dout_oe_o = dout_oe_r;
  assign gpio_o = gpio_r;
  assign gpio_oe_o = gpio_oe_r;
  assign pin_analog_o = analog_r;
  assign pin_enabled_o = enabled_r;
  assign offset_corr_value_o = {ofs_hi_r, ofs_lo_r};
  assign gain_corr_value_o = {gain_hi_r, gain_lo_r};
endmodule : cal_and_gpio_register_bank

// File: hdl/cal_gpio_pkg.sv
/*
  Constants for the calibration and pin register bank: register
  addresses, field positions, reset values and the serial frame layout.
  Assumes nothing of its surroundings.
*/
package cal_gpio_pkg;
  localparam int NPINS = 4;
  localparam int ADDR_W = 5;
  localparam int BYTE_W = 8;
  // command byte: bit 7 high = read, bits 4:0 = register address
  localparam int CMD_RD_BIT = 7;
  localparam logic [3:0] FRAME_BITS = 4'hF;
  localparam logic [3:0] CMD_LAST_BIT = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_OFS_LO = 5'h0B;
  localparam logic [ADDR_W-1:0] ADDR_OFS_HI = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_RSVD = 5'h0D;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_LO = 5'h0E;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_HI = 5'h0F;
  localparam logic [ADDR_W-1:0] ADDR_PIN_DAT = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_PIN_FUN = 5'h11;
  localparam logic [BYTE_W-1:0] RST_OFS_LO = 8'h00;
  localparam logic [BYTE_W-1:0] RST_OFS_HI = 8'h00;
  localparam logic [BYTE_W-1:0] RST_GAIN_LO = 8'h00;
  localparam logic [BYTE_W-1:0] RST_GAIN_HI = 8'h40;
  localparam logic [BYTE_W-1:0] RSVD_VAL = 8'h00;
  localparam logic [NPINS-1:0] RST_PIN_DIR = 4'h0;
  localparam logic [NPINS-1:0] RST_PIN_LEVEL = 4'h0;
  localparam logic [NPINS-1:0] RST_PIN_SEL = 4'h0;
  localparam int DIR_LSB = 4;
  localparam int LEVEL_LSB = 0;
  localparam int SEL_LSB = 0;
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_DATA = 3'b010,
    ST_DONE = 3'b100
  } link_state_t;
endpackage : cal_gpio_pkg

// File: testbench/cal_gpio_assertions.sv
/* Port checker for the register bank.
   Assumes the bench keeps each sclk phase at 200 ns. */
`timescale 1ns/10ps
module cal_gpio_checker #(
  parameter bit SIX_INPUT = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic [3:0] gpio_o,
  input wire logic [3:0] gpio_oe_o,
  input wire logic [3:0] pin_analog_o,
  input wire logic [3:0] pin_enabled_o,
  input wire logic [15:0] offset_corr_value_o,
  input wire logic [15:0] gain_corr_value_o
);
  default clocking @(posedge mclk_i); endclocking
  sequence cs_idle;
    cs_n_i[*5];
  endsequence
  sequence cs_active;
    (!cs_n_i)[*4];
  endsequence
  a_oe_in_frame: assert property (disable iff (!rstn_i)
    cs_active |-> dout_oe_o) else $error("dout not enabled in frame");
  a_oe_only_digital: assert property (disable iff (!rstn_i)
    (gpio_oe_o & pin_analog_o) == 4'h0) else $error("analog pin driven");
  a_out_needs_oe: assert property (disable iff (!rstn_i)
    (gpio_o & ~gpio_oe_o) == 4'h0) else $error("level on undriven pin");
  a_rst_cal_words: assert property (!rstn_i |=>
    offset_corr_value_o == 16'h0000 && gain_corr_value_o == 16'h4000)
    else $error("calibration reset value wrong");
  a_rst_pin_state: assert property (!rstn_i |=>
    gpio_oe_o == 4'h0 && gpio_o == 4'h0 && pin_analog_o == 4'hF)
    else $error("pin reset state wrong");
  a_dout_idle: assert property (disable iff (!rstn_i)
    cs_idle |-> !dout_oe_o && !dout_o) else $error("dout active idle");
  a_dout_on_rise: assert property (disable iff (!rstn_i)
    $changed(dout_o) && !cs_n_i |-> $past(sclk_i, 2))
    else $error("dout moved outside sclk high phase");
  a_cal_in_frame: assert property (disable iff (!rstn_i)
    $past(rstn_i) && ($changed(offset_corr_value_o)
    || $changed(gain_corr_value_o)) |-> !$past(cs_n_i, 4))
    else $error("calibration word changed outside a frame");
  a_pins_enabled: assert property (disable iff (!rstn_i)
    $past(rstn_i) |->
    pin_enabled_o == (SIX_INPUT ? ~pin_analog_o : 4'hF))
    else $error("pin enable wrong");
endmodule : cal_gpio_checker
bind cal_and_gpio_register_bank cal_gpio_checker #(.SIX_INPUT(SIX_INPUT))
  chk_i (.mclk_i, .rstn_i, .sclk_i, .cs_n_i, .dout_o, .dout_oe_o,
  .gpio_o, .gpio_oe_o, .pin_analog_o, .pin_enabled_o,
  .offset_corr_value_o, .gain_corr_value_o);

// File: testbench/serial_master_model.sv
/* Serial master in clock mode 1, 400 ns sclk.
   Assumes xfer is called at a falling mclk edge. */
`timescale 1ns/10ps
module serial_master_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] frame, input int nbits,
    output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    #200;
    for (int i = 15; i >= 16 - nbits; i--) begin
      sclk_o = 1'b1;
      din_o = frame[i];
      #200;
      sclk_o = 1'b0;
      rd = {rd[6:0], dout_i};
      #200;
    end
    #100;
    cs_n_o = 1'b1;
    din_o = ~din_o;
    #400;
  endtask : xfer
endmodule : serial_master_model

// File: testbench/cal_and_gpio_register_bank_tb.sv
/* Self-checking bench for the register bank.
   Assumes the serial master model and the bound checker. */
`timescale 1ns/10ps
module cal_and_gpio_register_bank_tb;
  import cal_gpio_pkg::*;
  logic mclk_i, rstn_i, sclk, cs_n, din, dout, dout_oe;
  logic [3:0] gpio_in, gpio_out, gpio_oe, ana, ena;
  logic [15:0] ofs, gain;
  logic [7:0] rd;
  logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40,
    8'h00, 8'h00};
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // six-input variant, so pins start disabled
  cal_and_gpio_register_bank #(.SIX_INPUT(1'b1)) uut (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout),
    .dout_oe_o(dout_oe), .gpio_i(gpio_in), .gpio_o(gpio_out),
    .gpio_oe_o(gpio_oe), .pin_analog_o(ana), .pin_enabled_o(ena),
    .offset_corr_value_o(ofs), .gain_corr_value_o(gain));
  serial_master_model mst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dout_i(dout));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    mst.xfer({3'b000, a, d}, 16, rd);
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    mst.xfer({3'b100, a, 8'h00}, 16, rd);
    chk({8'h00, rd}, {8'h00, e});
  endtask : rdc
  task automatic end_of_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    rstn_i = 1'b0;
    gpio_in = 4'h0;
    repeat (8) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    chk({8'h00, ana, ena}, 16'h00F0);
    foreach (rst_tab[i])
      rdc(ADDR_OFS_LO + 5'(i), rst_tab[i]);
    wr(ADDR_OFS_LO, 8'hA5);
    wr(ADDR_OFS_HI, 8'h5A);
    wr(ADDR_GAIN_LO, 8'h3C);
    wr(ADDR_GAIN_HI, 8'hC3);
    chk(ofs, 16'h5AA5);
    chk(gain, 16'hC33C);
    rdc(ADDR_OFS_HI, 8'h5A);
    rdc(ADDR_GAIN_HI, 8'hC3);
    wr(ADDR_RSVD, 8'h00);
    rdc(ADDR_RSVD, RSVD_VAL);
    rdc(5'h1F, 8'h00);
    // frame cut after ten bits must not write
    @(negedge mclk_i);
    mst.xfer({3'b000, ADDR_OFS_HI, 8'hFF}, 10, rd);
    chk(ofs, 16'h5AA5);
    wr(ADDR_PIN_DAT, 8'h4B);
    chk({8'h00, gpio_oe, gpio_out}, 16'h0000);
    chk({12'h000, ena}, 16'h0000);
    wr(ADDR_PIN_FUN, 8'h05);
    rdc(ADDR_PIN_FUN, 8'h05);
    chk({4'h0, ana, gpio_oe, gpio_out}, 16'h0A11);
    chk({12'h000, ena}, 16'h0005);
    gpio_in = 4'h4;
    rdc(ADDR_PIN_DAT, 8'h4F);
    gpio_in = 4'h0;
    rdc(ADDR_PIN_DAT, 8'h4B);
    wr(ADDR_PIN_DAT, 8'h0F);
    chk({4'h0, ana, gpio_oe, gpio_out}, 16'h0A55);
    wr(ADDR_PIN_FUN, 8'h00);
    chk({4'h0, ana, gpio_oe, gpio_out}, 16'h0F00);
    chk({12'h000, ena}, 16'h0000);
    end_of_test();
  end
endmodule : cal_and_gpio_register_bank_tb
